//--- verilog/ssp_pkg.sv
package ssp_pkg;

  localparam logic [3:0] STAT_REG = 4'h0;
  localparam logic [3:0] CON1_REG = 4'h1;
  localparam logic [3:0] BUF_REG  = 4'h2;
  localparam logic [3:0] CON2_REG = 4'h3;

  localparam int STAT_EN_BIT   = 15;
  localparam int STAT_IDLE_BIT = 13;
  localparam int STAT_OVF_BIT  = 6;
  localparam int STAT_TBF_BIT  = 1;
  localparam int STAT_RBF_BIT  = 0;

  localparam int CON1_CKDIS_BIT = 12;
  localparam int CON1_DODIS_BIT = 11;
  localparam int CON1_W16_BIT   = 10;
  localparam int CON1_SMP_BIT   = 9;
  localparam int CON1_CKE_BIT   = 8;
  localparam int CON1_SSU_BIT   = 7;
  localparam int CON1_CKP_BIT   = 6;
  localparam int CON1_MST_BIT   = 5;
  localparam int CON1_SEC_LSB   = 2;
  localparam int CON1_PRI_LSB   = 0;
  localparam int CON2_FRM_BIT   = 15;

  localparam logic [15:0] CON1_MASK  = 16'h1FFF;
  localparam logic [15:0] CON2_MASK  = 16'h8000;
  localparam logic [15:0] RESET_WORD = 16'h0000;

  localparam logic [7:0] PRI_DIV_64 = 8'h40;
  localparam logic [7:0] PRI_DIV_16 = 8'h10;
  localparam logic [7:0] PRI_DIV_4  = 8'h04;
  localparam logic [7:0] PRI_DIV_1  = 8'h01;

  typedef struct packed {
    logic       on;
    logic       halt_in_idle;
    logic       clock_pin_disable;
    logic       data_out_pin_disable;
    logic       word_width_select;
    logic       input_sample_phase;
    logic       clock_edge;
    logic       select_pin_use;
    logic       clock_idle_polarity;
    logic       master_role_select;
    logic [2:0] secondary_divider;
    logic [1:0] primary_divider;
    logic       framing_enable;
  } ssp_cfg_type;

  typedef struct packed {
    logic sck;
    logic sdo;
    logic ss_n;
  } ssp_pins_type;

  typedef enum logic [1:0] {
    SSP_IDLE,
    SSP_LEAD,
    SSP_TRAIL
  } ssp_state_type;

endpackage

//--- verilog/ssp_serial_port.sv
`timescale 1ns/1ps
// Functional notes
// - A 16-bit shift register plus a buffer location exchanges data with software.
// - Four lines: data in, data out, shift clock, active-low select.
// - Master role drives the shift clock; slave role takes it in.
// - Enable bit gives pins to the port; clearing it disables the port.
// - Halt-in-idle bit stops the port while the device idles.
// - Word completed while previous unread sets overflow and is discarded.
// - Buffer write loads transmit buffer and sets transmit-full.
// - Transmit-full clears when transmit buffer moves to shift register.
// - Completed word moved to receive buffer sets receive-full.
// - Buffer read returns receive buffer and clears receive-full.
// - Master clock-disable bit releases the clock pin; the clock keeps running inside the port.
// - Data-out-disable bit releases the data pin; otherwise the port drives it.
// - Width bit picks 16-bit words when set, 8-bit when clear.
// - Master samples at end of data time when set, middle when clear.
// - Clock-edge bit set: data changes active-to-idle; clear: idle-to-active.
// - Slave select-use bit makes the port honour the select pin.
// - Polarity bit set: clock idles high; clear: clock idles low.
// - Framing bit turns select pin into a frame sync pulse in master role only; a slave ignores it.
module ssp_serial_port
  import ssp_pkg::*;
#(
  parameter int WORD_W = 16
) (
  input  wire logic        clk_i,
  input  wire logic        srst_i,
  input  wire logic [3:0]  addr_i,
  input  wire logic [15:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [15:0] rdata_o,
  input  wire logic        device_idle_i,
  input  wire logic        sdi_i,
  input  wire logic        sck_i,
  input  wire logic        ss_n_i,
  output logic             sdo_o,
  output logic             sdo_oe_o,
  output logic             sck_o,
  output logic             sck_oe_o,
  output logic             ss_n_o,
  output logic             ss_n_oe_o
);

  function automatic logic [7:0] pri_div(input logic [1:0] code);
    case (code)
      2'h0:    pri_div = PRI_DIV_64;
      2'h1:    pri_div = PRI_DIV_16;
      2'h2:    pri_div = PRI_DIV_4;
      default: pri_div = PRI_DIV_1;
    endcase
  endfunction

  ssp_cfg_type         cfg;
  logic [WORD_W-1:0]   shift_register;
  logic [WORD_W-1:0]   transmit_buffer;
  logic [WORD_W-1:0]   receive_buffer;
  logic                transmit_full_flag;
  logic                receive_full_flag;
  logic                receive_overflow_flag;
  ssp_state_type       state;
  logic [4:0]          bit_cnt;
  logic [10:0]         div_cnt;
  logic                sck_int;
  logic                sampled_bit;
  logic                sdo_q;
  logic                frame_q;
  logic [2:0]          sdi_s;
  logic [2:0]          sck_s;
  logic [2:0]          ss_s;
  logic [15:0]         rdata;
  logic                sck_q;

  wire        wr_buf   = wr_i && (addr_i == BUF_REG);
  wire        rd_buf   = rd_i && (addr_i == BUF_REG);
  wire        wr_stat  = wr_i && (addr_i == STAT_REG);
  wire        wr_con1  = wr_i && (addr_i == CON1_REG);
  wire        wr_con2  = wr_i && (addr_i == CON2_REG);
  wire        run      = cfg.on && !(cfg.halt_in_idle && device_idle_i);
  wire        master   = cfg.master_role_select;
  wire [4:0]  last_bit = cfg.word_width_select ? 5'h0F : 5'h07;
  wire [10:0] half_div = {3'h0, pri_div(cfg.primary_divider)}
                         * ({8'h00, 3'h7 - cfg.secondary_divider} + 11'h1);
  wire        div_tick = (div_cnt >= half_div - 11'h1);
  // Link edges found from the synchronised shift clock; slice 1 and 2 are past the first stage.
  wire        sck_sync = sck_s[1];
  wire        sck_prev = sck_s[2];
  wire        ss_sync  = ss_s[1];
  wire        sdi_sync = sdi_s[1];
  // Leading edge leaves idle level, trailing edge returns to it.
  wire        lead_in  = (sck_sync != sck_prev) && (sck_sync != cfg.clock_idle_polarity);
  wire        trail_in = (sck_sync != sck_prev) && (sck_sync == cfg.clock_idle_polarity);
  // Select pin honoured only when select use is on.
  wire        slave_ok = !cfg.select_pin_use || !ss_sync;
  wire        m_lead   = master && (state == SSP_LEAD) && div_tick;
  wire        m_trail  = master && (state == SSP_TRAIL) && div_tick;
  wire        lead_ev  = master ? m_lead : (run && slave_ok && lead_in);
  wire        trail_ev = master ? m_trail : (run && slave_ok && trail_in);
  // Clock-edge bit picks which edge shifts out and which samples in.
  wire        shift_ev = cfg.clock_edge ? trail_ev : lead_ev;
  wire        samp_mid = cfg.clock_edge ? lead_ev : trail_ev;
  // Master end-of-time sampling uses the shifting edge.
  wire        samp_ev  = (master && cfg.input_sample_phase) ? shift_ev : samp_mid;
  wire        word_end = shift_ev && (bit_cnt == last_bit) && (state != SSP_IDLE);
  wire        load_ok  = transmit_full_flag && run && (state == SSP_IDLE);
  wire [WORD_W-1:0] next_shift = {shift_register[WORD_W-2:0], sampled_bit};

  // Buffer read returns the receive buffer.
  assign rdata = (addr_i == STAT_REG) ? {cfg.on, 1'b0, cfg.halt_in_idle, 6'h00,
                                         receive_overflow_flag, 4'h0,
                                         transmit_full_flag, receive_full_flag} :
                 (addr_i == CON1_REG) ? {3'h0, cfg.clock_pin_disable,
                                         cfg.data_out_pin_disable, cfg.word_width_select,
                                         cfg.input_sample_phase, cfg.clock_edge,
                                         cfg.select_pin_use, cfg.clock_idle_polarity,
                                         cfg.master_role_select, cfg.secondary_divider,
                                         cfg.primary_divider} :
                 (addr_i == BUF_REG)  ? receive_buffer :
                 (addr_i == CON2_REG) ? {cfg.framing_enable, 15'h0000} : 16'h0000;

  // Pins belong to the port only while enabled.
  // Clock pin released when disabled in master role.
  assign sck_oe_o  = cfg.on && master && !cfg.clock_pin_disable;
  assign sck_o     = sck_q;
  // Data pin released when data-out is disabled.
  assign sdo_oe_o  = cfg.on && !cfg.data_out_pin_disable;
  assign sdo_o     = sdo_q;
  // Master framing drives an active-low sync pulse on the select pin.
  assign ss_n_oe_o = cfg.on && master && cfg.framing_enable;
  assign ss_n_o    = !frame_q;

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      sdi_s <= 3'h0;
      sck_s <= 3'h0;
      ss_s  <= 3'h7;
    end else begin
      sdi_s <= {sdi_s[1:0], sdi_i};
      sck_s <= {sck_s[1:0], sck_i};
      ss_s  <= {ss_s[1:0], ss_n_i};
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      cfg <= '0;
      rdata_o <= RESET_WORD;
    end else begin
      rdata_o <= rd_i ? rdata : RESET_WORD;
      if (wr_stat) begin
        cfg.on           <= wdata_i[STAT_EN_BIT];
        cfg.halt_in_idle <= wdata_i[STAT_IDLE_BIT];
      end
      if (wr_con1) begin
        cfg.clock_pin_disable    <= wdata_i[CON1_CKDIS_BIT];
        cfg.data_out_pin_disable <= wdata_i[CON1_DODIS_BIT];
        cfg.word_width_select    <= wdata_i[CON1_W16_BIT];
        cfg.input_sample_phase   <= wdata_i[CON1_SMP_BIT];
        cfg.clock_edge           <= wdata_i[CON1_CKE_BIT];
        cfg.select_pin_use       <= wdata_i[CON1_SSU_BIT];
        cfg.clock_idle_polarity  <= wdata_i[CON1_CKP_BIT];
        cfg.master_role_select   <= wdata_i[CON1_MST_BIT];
        cfg.secondary_divider    <= wdata_i[CON1_SEC_LSB +: 3];
        cfg.primary_divider      <= wdata_i[CON1_PRI_LSB +: 2];
      end
      if (wr_con2) begin
        cfg.framing_enable <= wdata_i[CON2_FRM_BIT];
      end
    end
  end

  // Buffer write loads and sets full; move clears it.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      transmit_buffer    <= '0;
      transmit_full_flag <= 1'b0;
    end else begin
      if (wr_buf) begin
        transmit_buffer <= wdata_i[WORD_W-1:0];
      end
      transmit_full_flag <= wr_buf || (transmit_full_flag && !load_ok);
    end
  end

  // Receive-full set on move; overflow keeps old word.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      receive_buffer        <= '0;
      receive_full_flag     <= 1'b0;
      receive_overflow_flag <= 1'b0;
    end else begin
      if (word_end && !receive_full_flag) begin
        receive_buffer <= cfg.word_width_select ? next_shift
                          : {8'h00, next_shift[7:0]};
      end
      // Read clears receive-full; a word ending with the read is discarded as overflow.
      receive_full_flag <= (word_end && !receive_full_flag)
                           || (receive_full_flag && !rd_buf);
      receive_overflow_flag <= (word_end && receive_full_flag)
                               || (receive_overflow_flag
                                   && !(wr_stat && !wdata_i[STAT_OVF_BIT]));
    end
  end

  // Shift engine; master starts when loaded, MSB first.
  always_ff @(posedge clk_i) begin
    if (srst_i || !run) begin
      state          <= SSP_IDLE;
      shift_register <= '0;
      bit_cnt        <= 5'h00;
      div_cnt        <= 11'h000;
      sampled_bit    <= 1'b0;
      sdo_q          <= 1'b0;
      frame_q        <= 1'b0;
      // A stopped port holds the clock at its idle level.
      sck_q          <= !srst_i && cfg.clock_idle_polarity;
    end else begin
      div_cnt <= (state == SSP_IDLE || div_tick) ? 11'h000 : div_cnt + 11'h001;
      if (samp_ev) begin
        sampled_bit <= sdi_sync;
      end
      if (load_ok) begin
        shift_register <= transmit_buffer;
        bit_cnt        <= 5'h00;
        state          <= SSP_LEAD;
        frame_q        <= master && cfg.framing_enable;
        sdo_q          <= cfg.word_width_select ? transmit_buffer[15] : transmit_buffer[7];
      end else if (shift_ev && state != SSP_IDLE) begin
        shift_register <= next_shift;
        bit_cnt        <= bit_cnt + 5'h01;
        sdo_q          <= cfg.word_width_select ? next_shift[15] : next_shift[7];
        frame_q        <= 1'b0;
      end
      if (master && m_lead) begin
        state <= SSP_TRAIL;
      end else if (master && m_trail) begin
        state <= (bit_cnt == last_bit) ? SSP_IDLE : SSP_LEAD;
      end else if (!master && word_end) begin
        state <= SSP_IDLE;
      end else if (!master && state == SSP_IDLE && !load_ok && lead_ev) begin
        state <= SSP_LEAD;
      end
      // Master generates the clock; idle level from polarity.
      sck_q <= (master && state == SSP_TRAIL && !(m_trail))
               || (master && m_lead) ? !cfg.clock_idle_polarity
                                     : cfg.clock_idle_polarity;
    end
  end

endmodule

//--- tb/ssp_far_model.sv
`timescale 1ns/1ps
module ssp_far_model (
  input  wire logic sck_i,
  input  wire logic cpol_i,
  input  wire logic sdo_i,
  output logic      sdi_o
);
  logic [15:0] tx;
  logic [15:0] rx;
  int          cnt = 0;
  int          width = 0;
  initial sdi_o = 1'b0;
  task automatic load(input logic [15:0] w, input int n);
    tx = w;
    rx = 16'h0000;
    width = n;
    cnt = 0;
    sdi_o = w[n-1];
  endtask
  // Capture on leading, shift on trailing edge.
  always @(sck_i) begin
    if (sck_i !== cpol_i && cnt < width) begin
      rx = {rx[14:0], sdo_i};
      cnt++;
    end else if (sck_i === cpol_i && cnt < width) begin
      sdi_o = tx[width-1-cnt];
    end else if (sck_i === cpol_i && cnt == width) begin
      sdi_o = ~sdi_o;
      cnt++;
    end
  end
endmodule

//--- tb/ssp_serial_port_chk.sv
`timescale 1ns/1ps
module ssp_serial_port_chk
  import ssp_pkg::*;
#(
  parameter int WORD_W = 16
) (
  input wire logic        clk_i,
  input wire logic        srst_i,
  input wire logic [3:0]  addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic        wr_i,
  input wire logic        rd_i,
  input wire logic [15:0] rdata_o,
  input wire logic        device_idle_i,
  input wire logic        sck_o,
  input wire logic        sck_oe_o,
  input wire logic        sdo_oe_o,
  input wire logic        ss_n_oe_o
);
  logic        on_q;
  logic        halt_q;
  logic        frm_q;
  logic [15:0] c1_q;
  wire         st_wr = wr_i && addr_i == STAT_REG;
  wire         stop  = on_q && halt_q && device_idle_i;
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      on_q   <= 1'b0;
      halt_q <= 1'b0;
      frm_q  <= 1'b0;
      c1_q   <= 16'h0000;
    end else begin
      if (st_wr) on_q <= wdata_i[STAT_EN_BIT];
      if (st_wr) halt_q <= wdata_i[STAT_IDLE_BIT];
      if (wr_i && addr_i == CON1_REG) c1_q <= wdata_i & CON1_MASK;
      if (wr_i && addr_i == CON2_REG) frm_q <= wdata_i[CON2_FRM_BIT];
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (srst_i);
  sequence s_buf_wr; wr_i && addr_i == BUF_REG; endsequence
  sequence s_buf_rd; rd_i && addr_i == BUF_REG; endsequence
  sequence s_stat_rd; rd_i && addr_i == STAT_REG; endsequence
  sequence s_ovf_clr; st_wr && !wdata_i[STAT_OVF_BIT]; endsequence
  property p_rd_idle; !rd_i |=> rdata_o == 16'h0000; endproperty
  property p_tbf; s_buf_wr ##1 s_stat_rd |=> rdata_o[STAT_TBF_BIT]; endproperty
  property p_rbf_clr; s_buf_rd ##2 s_stat_rd |=> !rdata_o[STAT_RBF_BIT]; endproperty
  property p_ovf_clr; s_ovf_clr ##2 s_stat_rd |=> !rdata_o[STAT_OVF_BIT]; endproperty
  property p_sdo_oe; sdo_oe_o == (on_q && !c1_q[CON1_DODIS_BIT]); endproperty
  property p_sck_oe;
    sck_oe_o == (on_q && c1_q[CON1_MST_BIT] && !c1_q[CON1_CKDIS_BIT]);
  endproperty
  property p_idle_pol; $rose(sck_oe_o) |-> sck_o == c1_q[CON1_CKP_BIT]; endproperty
  property p_ss_oe; ss_n_oe_o |-> frm_q && on_q && c1_q[CON1_MST_BIT]; endproperty
  property p_halt; stop [*4] |-> $stable(sck_o); endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not zero");
  a_tbf: assert property (p_tbf) else $error("transmit full not set");
  a_rbf_clr: assert property (p_rbf_clr) else $error("receive full kept");
  a_ovf_clr: assert property (p_ovf_clr) else $error("overflow kept");
  a_sdo_oe: assert property (p_sdo_oe) else $error("data enable wrong");
  a_sck_oe: assert property (p_sck_oe) else $error("clock enable wrong");
  a_idle_pol: assert property (p_idle_pol) else $error("idle level wrong");
  a_ss_oe: assert property (p_ss_oe) else $error("sync enable wrong");
  a_halt: assert property (p_halt) else $error("clock moved in idle");
endmodule
bind ssp_serial_port ssp_serial_port_chk #(.WORD_W(WORD_W)) u_chk (
  .clk_i(clk_i), .srst_i(srst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
  .rd_i(rd_i), .rdata_o(rdata_o), .device_idle_i(device_idle_i), .sck_o(sck_o),
  .sck_oe_o(sck_oe_o), .sdo_oe_o(sdo_oe_o), .ss_n_oe_o(ss_n_oe_o)
);

//--- tb/test_ssp_serial_port.sv
`timescale 1ns/1ps
module test_ssp_serial_port
  import ssp_pkg::*;
;
  logic        clk_i         = 1'b0;
  logic        srst_i        = 1'b1;
  logic [3:0]  addr_i        = 4'h0;
  logic [15:0] wdata_i       = 16'h0000;
  logic        wr_i          = 1'b0;
  logic        rd_i          = 1'b0;
  logic        device_idle_i = 1'b0;
  logic        cpol          = 1'b0;
  logic        lsck          = 1'b0;
  logic [15:0] rdata_o;
  logic        sdi;
  logic        sdo;
  logic        sdo_oe;
  logic        sck;
  logic        sck_oe;
  logic [15:0] st;
  int          errors        = 0;
  int          checks        = 0;
  ssp_serial_port #(.WORD_W(16)) u_dut (
    .clk_i(clk_i), .srst_i(srst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .device_idle_i(device_idle_i), .sdi_i(sdi),
    .sck_i(lsck), .ss_n_i(1'b1), .sdo_o(sdo), .sdo_oe_o(sdo_oe), .sck_o(sck),
    .sck_oe_o(sck_oe), .ss_n_o(), .ss_n_oe_o()
  );
  ssp_far_model u_far (.sck_i(sck_oe ? sck : lsck), .cpol_i(cpol), .sdo_i(sdo), .sdi_o(sdi));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic results;
    $display("checks=%0d errors=%0d", checks, errors);
    if (errors == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
    @(posedge clk_i);
    #1;
  endtask
  task automatic rd(input logic [3:0] a, output logic [15:0] q);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 q = rdata_o;
    @(posedge clk_i);
  endtask
  task automatic start(input logic [15:0] tx, sw, input int n, input logic [15:0] exp);
    u_far.load(sw, n);
    addr_i <= BUF_REG;
    wdata_i <= tx;
    wr_i <= 1'b1;
    @(posedge clk_i);
    addr_i <= STAT_REG;
    wr_i <= 1'b0;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 chk(rdata_o, exp);
  endtask
  task automatic finish(input logic [15:0] exp);
    st = 16'h0000;
    for (int i = 0; i < 300 && st !== exp; i++) rd(STAT_REG, st);
    chk(st, exp);
  endtask
  initial forever #5 clk_i = ~clk_i;
  initial begin
    repeat (20000) @(posedge clk_i);
    errors++;
    results();
  end
  initial begin
    repeat (3) @(posedge clk_i);
    srst_i <= 1'b0;
    @(posedge clk_i);
    for (int a = 0; a < 16; a++) begin
      rd(4'(a), st);
      chk(st, 16'h0000);
    end
    // Master, 16-bit, dividers one and four.
    wr(CON1_REG, 16'h0533);
    wr(STAT_REG, 16'h8000);
    chk({14'h0, sck_oe, sdo_oe}, 16'h0003);
    chk({15'h0, sck}, 16'h0000);
    start(16'hA5C3, 16'h3C5A, 16, 16'h8002);
    finish(16'h8001);
    chk(u_far.rx, 16'hA5C3);
    rd(BUF_REG, st);
    chk(st, 16'h3C5A);
    rd(STAT_REG, st);
    chk(st, 16'h8000);
    cpol <= 1'b1;
    wr(CON1_REG, 16'h0173);
    chk({15'h0, sck}, 16'h0001);
    start(16'h12B4, 16'h00E7, 8, 16'h8002);
    finish(16'h8001);
    chk(u_far.rx, 16'h00B4);
    start(16'h0F0F, 16'h0081, 8, 16'h8003);
    finish(16'h8041);
    rd(BUF_REG, st);
    chk(st, 16'h00E7);
    wr(STAT_REG, 16'h8000);
    rd(STAT_REG, st);
    chk(st, 16'h8000);
    wr(STAT_REG, 16'hA000);
    device_idle_i <= 1'b1;
    start(16'h0055, 16'h00C3, 8, 16'hA002);
    repeat (60) @(posedge clk_i);
    rd(STAT_REG, st);
    chk(st, 16'hA002);
    chk({15'h0, sck}, 16'h0001);
    device_idle_i <= 1'b0;
    finish(16'hA001);
    chk(u_far.rx, 16'h0055);
    rd(BUF_REG, st);
    chk(st, 16'h00C3);
    cpol <= 1'b0;
    // Slave role with sample phase and select use clear.
    wr(CON1_REG, 16'h0100);
    wr(STAT_REG, 16'h8000);
    chk({14'h0, sck_oe, sdo_oe}, 16'h0001);
    start(16'h0096, 16'h005C, 8, 16'h8002);
    repeat (8) begin
      #62.5 lsck = 1'b1;
      #62.5 lsck = 1'b0;
    end
    finish(16'h8001);
    chk(u_far.rx, 16'h0096);
    rd(BUF_REG, st);
    chk(st, 16'h005C);
    wr(CON1_REG, 16'h1D33);
    chk({14'h0, sck_oe, sdo_oe}, 16'h0000);
    wr(STAT_REG, 16'h0000);
    results();
  end
endmodule
